// ==== rtl/usb_port_pkg.sv ====
package usb_port_pkg;
  localparam int MEM_BYTES = 256;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 250;
  localparam logic [7:0] HOST_BUF_START = 8'h10;
  localparam logic [7:0] PERIPH_BUF_START = 8'h40;
  localparam logic [7:0] ADDR_SET_A_BASE = 8'h01;
  localparam logic [7:0] ADDR_SET_A_LEN = 8'h02;
  localparam logic [7:0] ADDR_SET_B_BASE = 8'h09;
  localparam logic [7:0] ADDR_SET_B_LEN = 8'h0A;
  localparam logic [7:0] ADDR_HOST_IRQ_EN = 8'h06;
  localparam logic [7:0] ADDR_HOST_IRQ_STAT = 8'h0D;
  localparam logic [7:0] ADDR_PERIPH_IRQ_EN = 8'h3E;
  localparam logic [7:0] ADDR_PERIPH_IRQ_STAT = 8'h3F;
  localparam logic [7:0] ADDR_FULL_FEATURE = 8'h0F;
  localparam logic [7:0] ADDR_DMA_COUNT = 8'h3B;
  localparam logic [7:0] ADDR_DMA_ADDR = 8'h3C;
  localparam logic [7:0] ADDR_DMA_CTRL = 8'h3D;
  localparam int DMA_EN_BIT = 0;
  localparam int DMA_DIR_BIT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic clock_multiply_pin;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic addr_data_select;
    logic dma_ack_n;
    logic [7:0] data;
  } pins_s;

  localparam pins_s PINS_IDLE = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 8'h00};

  typedef struct packed {
    logic wr;
    logic rd;
    logic set_b;
    logic [7:0] index;
    logic [7:0] wdata;
  } usb_req_s;
endpackage : usb_port_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins and synchronised copy
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s.s1 = d_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s <= {INIT, INIT};
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.s2;
endmodule : pin_sync
`default_nettype wire

// ==== rtl/byte_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s s;
  fifo_s next_s;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  always_comb begin
    next_s = s;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push) begin
      next_s.mem[s.wp] = in_data_in;
      next_s.wp = step(s.wp);
    end
    if (pop) begin
      next_s.rp = step(s.rp);
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready_out = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (s.cnt != '0);
  assign out_data_out = s.mem[s.rp];
endmodule : byte_fifo
`default_nettype wire

// ==== rtl/usb_ctrl_cpu_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_ctrl_cpu_port #(
  parameter int FIFO_DEPTH = usb_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Processor pins
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic addr_data_select_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // DMA and interrupt pins
  input wire logic dma_ack_n_in,
  output logic dma_request_n_out,
  output logic irq_out,
  // Clocking and mode
  input wire logic clock_multiply_pin_in,
  input wire logic peripheral_mode_in,
  output logic pll_bypass_out,
  output logic full_feature_out,
  // USB engine side
  input wire usb_port_pkg::usb_req_s usb_req_in,
  input wire logic [7:0] usb_event_in,
  output logic [7:0] usb_rdata_out,
  output logic usb_overrun_out
);
  import usb_port_pkg::*;

  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] mem;
    logic [7:0] ptr;
    logic wr_act;
    logic wr_a0;
    logic wr_dma;
    logic [7:0] wdata;
    logic rd_act;
    logic rd_a0;
    logic rd_dma;
    logic [7:0] rdata;
    logic [7:0] status;
    logic full_feature;
    logic dma_en;
    logic dma_dir;
    logic [7:0] dma_ptr;
    logic [7:0] dma_cnt;
    logic pll_bypass;
    logic [7:0] usb_rdata;
    logic usb_overrun;
  } port_s;

  port_s s;
  port_s next_s;
  pins_s raw;
  pins_s p;
  logic dma_on;
  logic wr_now;
  logic rd_now;
  logic wr_end;
  logic cpu_commit;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic drain;
  logic [7:0] fifo_data;
  logic [7:0] clr;
  logic [7:0] ubase;
  logic [7:0] ulen;
  logic [7:0] uaddr;

  function automatic logic [7:0] stat_addr(input logic periph);
    stat_addr = periph ? ADDR_PERIPH_IRQ_STAT : ADDR_HOST_IRQ_STAT;
  endfunction : stat_addr

  function automatic logic [7:0] en_addr(input logic periph);
    en_addr = periph ? ADDR_PERIPH_IRQ_EN : ADDR_HOST_IRQ_EN;
  endfunction : en_addr

  function automatic logic [7:0] buf_start(input logic periph);
    buf_start = periph ? PERIPH_BUF_START : HOST_BUF_START;
  endfunction : buf_start

  // Every pin but peripheral_mode_in, the data bus included, is brought onto clk_in before use.
  assign raw = '{clock_multiply_pin_in, chip_select_n_in, write_strobe_n_in,
                 read_strobe_n_in, addr_data_select_in, dma_ack_n_in, data_in};

  pin_sync #(
    .W($bits(pins_s)),
    .INIT(PINS_IDLE)
  ) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(raw),
    .q_out(p)
  );

  // DMA write bytes are queued so a busy memory cycle loses none unless the queue is full, when the byte is dropped.
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(s.wdata),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(drain),
    .out_data_out(fifo_data)
  );

  always_comb begin
    next_s = s;
    dma_on = peripheral_mode_in && s.dma_en;
    wr_now = !p.write_strobe_n && (!p.chip_select_n || (!p.dma_ack_n && dma_on));
    rd_now = !p.read_strobe_n && (!p.chip_select_n || (!p.dma_ack_n && dma_on));
    wr_end = s.wr_act && !wr_now;
    cpu_commit = wr_end && !s.wr_dma;
    push = 1'h0;
    clr = 8'h00;
    if (wr_now) begin
      next_s.wr_act = 1'h1;
      next_s.wr_a0 = p.addr_data_select;
      next_s.wr_dma = !p.dma_ack_n && dma_on;
      next_s.wdata = p.data;
    end else if (s.wr_act) begin
      next_s.wr_act = 1'h0;
      if (s.wr_dma) begin
        push = fifo_in_ready;
        next_s.dma_cnt = s.dma_cnt - 8'h01;
        next_s.dma_en = (s.dma_cnt != 8'h01);
      end else if (!s.wr_a0) begin
        next_s.ptr = s.wdata;
      end else begin
        next_s.ptr = s.ptr + 8'h01;
        if (s.ptr == stat_addr(peripheral_mode_in)) begin
          clr = s.wdata;
        end else begin
          next_s.mem[s.ptr] = s.wdata;
        end
        if (s.ptr == ADDR_FULL_FEATURE) begin
          next_s.full_feature = 1'h1;
        end
        if (peripheral_mode_in && s.ptr == ADDR_DMA_CTRL && s.wdata[DMA_EN_BIT]) begin
          next_s.dma_en = (s.mem[ADDR_DMA_COUNT] != 8'h00);
          next_s.dma_dir = s.wdata[DMA_DIR_BIT];
          next_s.dma_cnt = s.mem[ADDR_DMA_COUNT];
          next_s.dma_ptr = s.mem[ADDR_DMA_ADDR];
        end
      end
    end
    if (rd_now && !s.rd_act) begin
      next_s.rd_act = 1'h1;
      next_s.rd_a0 = p.addr_data_select;
      next_s.rd_dma = !p.dma_ack_n && dma_on;
      if (!p.dma_ack_n && dma_on) begin
        next_s.rdata = s.mem[s.dma_ptr];
      end else if (!p.addr_data_select) begin
        next_s.rdata = s.ptr;
      end else if (s.ptr == stat_addr(peripheral_mode_in)) begin
        next_s.rdata = s.status;
      end else begin
        next_s.rdata = s.mem[s.ptr];
      end
    end else if (!rd_now && s.rd_act) begin
      next_s.rd_act = 1'h0;
      if (s.rd_dma) begin
        next_s.dma_ptr = s.dma_ptr + 8'h01;
        next_s.dma_cnt = s.dma_cnt - 8'h01;
        next_s.dma_en = (s.dma_cnt != 8'h01);
      end else if (s.rd_a0) begin
        next_s.ptr = s.ptr + 8'h01;
      end
    end
    // A register write from the processor takes the memory cycle; the queue waits.
    drain = fifo_out_valid && !cpu_commit && !(rd_now && !s.rd_act);
    if (drain) begin
      next_s.mem[s.dma_ptr] = fifo_data;
      next_s.dma_ptr = s.dma_ptr + 8'h01;
    end
    ubase = (usb_req_in.set_b && s.full_feature) ? s.mem[ADDR_SET_B_BASE] : s.mem[ADDR_SET_A_BASE];
    ulen = (usb_req_in.set_b && s.full_feature) ? s.mem[ADDR_SET_B_LEN] : s.mem[ADDR_SET_A_LEN];
    uaddr = ubase + usb_req_in.index;
    // Addresses below the buffer start of the current mode are never reachable through the USB path.
    next_s.usb_overrun = (usb_req_in.wr || usb_req_in.rd) &&
                         (usb_req_in.index >= ulen || ubase < buf_start(peripheral_mode_in) ||
                          uaddr < ubase);
    if (usb_req_in.wr && !next_s.usb_overrun) begin
      next_s.mem[uaddr] = usb_req_in.wdata;
    end
    if (usb_req_in.rd && !next_s.usb_overrun) begin
      next_s.usb_rdata = s.mem[uaddr];
    end
    next_s.status = (s.status & ~clr) | usb_event_in;
    next_s.pll_bypass = !p.clock_multiply_pin;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign data_out = s.rdata;
  assign data_oe_out = s.rd_act;
  // Request drops while the queue is full so the controller backs off.
  assign dma_request_n_out = !(dma_on && (!s.dma_dir || fifo_in_ready));
  assign irq_out = |(s.status & s.mem[en_addr(peripheral_mode_in)]);
  assign pll_bypass_out = s.pll_bypass;
  assign full_feature_out = s.full_feature;
  assign usb_rdata_out = s.usb_rdata;
  assign usb_overrun_out = s.usb_overrun;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_wr_ends;
    s.wr_act && !s.wr_dma && (p.write_strobe_n || p.chip_select_n) |=> !s.wr_act;
  endproperty
  a_wr_ends: assert property (p_wr_ends) else $error("write access did not end");

  property p_addr_load;
    $fell(s.wr_act) && !$past(s.wr_dma) && !$past(s.wr_a0) |-> s.ptr == $past(s.wdata);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address write not loaded");

  property p_wr_incr;
    $fell(s.wr_act) && !$past(s.wr_dma) && $past(s.wr_a0) |-> s.ptr == $past(s.ptr) + 8'h01;
  endproperty
  a_wr_incr: assert property (p_wr_incr) else $error("pointer not advanced on write");

  property p_rd_incr;
    $fell(s.rd_act) && !$past(s.rd_dma) && $past(s.rd_a0) |-> s.ptr == $past(s.ptr) + 8'h01;
  endproperty
  a_rd_incr: assert property (p_rd_incr) else $error("pointer not advanced on read");

  property p_no_host_dma;
    !peripheral_mode_in |-> dma_request_n_out && !dma_on;
  endproperty
  a_no_host_dma: assert property (p_no_host_dma) else $error("DMA active in host mode");

  property p_dma_count;
    $fell(s.rd_act) && $past(s.rd_dma) |-> s.dma_cnt == $past(s.dma_cnt) - 8'h01;
  endproperty
  a_dma_count: assert property (p_dma_count) else $error("DMA count not decremented");

  property p_irq_raise;
    usb_event_in[0] && s.mem[en_addr(peripheral_mode_in)][0] && !cpu_commit && $stable(peripheral_mode_in)
      |=> irq_out;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled event gave no interrupt");

  property p_irq_clear;
    cpu_commit && s.wr_a0 && s.ptr == stat_addr(peripheral_mode_in) && s.wdata[0] && !usb_event_in[0]
      |=> !s.status[0];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

  property p_full_feature;
    cpu_commit && s.wr_a0 && s.ptr == ADDR_FULL_FEATURE |=> full_feature_out [*2];
  endproperty
  a_full_feature: assert property (p_full_feature) else $error("full-feature bit not set");

  property p_pll_bypass;
    !clock_multiply_pin_in [*3] |=> pll_bypass_out;
  endproperty
  a_pll_bypass: assert property (p_pll_bypass) else $error("PLL not bypassed");

  c_addr_load: cover property ($fell(s.wr_act) && !$past(s.wr_a0));
  c_dma_read: cover property ($fell(s.rd_act) && $past(s.rd_dma));
  c_irq: cover property ($rose(irq_out));
  c_fifo_full: cover property (!fifo_in_ready);
endmodule : usb_ctrl_cpu_port
`default_nettype wire

// ==== test/cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
  // Clock
  input wire logic clk_in,
  // Shared data wire
  input wire logic [7:0] bus_in,
  // Pins toward the port
  output logic chip_select_n_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic addr_data_select_out,
  output logic dma_ack_n_out,
  output logic [7:0] data_out
);
  initial begin
    chip_select_n_out = 1'b1;
    write_strobe_n_out = 1'b1;
    read_strobe_n_out = 1'b1;
    addr_data_select_out = 1'b0;
    dma_ack_n_out = 1'b1;
    data_out = 8'hA5;
  end

  // Strobes stay low four edges, so the read answer is settled when it is taken.
  task automatic access(input logic wr, input logic sel, input logic dma, input logic cs_first,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge clk_in);
    chip_select_n_out <= dma;
    dma_ack_n_out <= ~dma;
    addr_data_select_out <= sel;
    write_strobe_n_out <= ~wr;
    read_strobe_n_out <= wr;
    data_out <= wr ? wdata : ~data_out;
    repeat (4) @(posedge clk_in);
    rdata = bus_in;
    chip_select_n_out <= 1'b1;
    if (cs_first) begin
      @(posedge clk_in);
    end
    write_strobe_n_out <= 1'b1;
    read_strobe_n_out <= 1'b1;
    dma_ack_n_out <= 1'b1;
    // A released bus must not keep showing the last byte.
    data_out <= ~data_out;
    // The port commits three edges after release, so a fourth edge lets callers look at settled state.
    repeat (4) @(posedge clk_in);
  endtask : access
endmodule : cpu_model
`default_nettype wire

// ==== test/usb_ctrl_cpu_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_ctrl_cpu_port_tb;
  import usb_port_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cs_n, wr_n, rd_n, sel, dack_n, cm_pin, periph_mode;
  logic oe, drq_n, irq, bypass, full_feat, overrun;
  logic [7:0] cpu_d, dut_d, bus, usb_event, usb_rdata, rd_b, a, d;
  logic [7:0] img [16];
  usb_req_s usb_req;
  logic [31:0] seed = 32'd18685;
  int failures = 0;
  int n_tests = 0;

  always #2 clk_in = ~clk_in;
  assign bus = oe ? dut_d : cpu_d;

  cpu_model u_cpu (.clk_in(clk_in), .bus_in(bus), .chip_select_n_out(cs_n), .write_strobe_n_out(wr_n),
    .read_strobe_n_out(rd_n), .addr_data_select_out(sel), .dma_ack_n_out(dack_n), .data_out(cpu_d));

  usb_ctrl_cpu_port #(.FIFO_DEPTH(4)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .chip_select_n_in(cs_n),
    .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .addr_data_select_in(sel), .data_in(bus),
    .data_out(dut_d), .data_oe_out(oe), .dma_ack_n_in(dack_n), .dma_request_n_out(drq_n), .irq_out(irq),
    .clock_multiply_pin_in(cm_pin), .peripheral_mode_in(periph_mode), .pll_bypass_out(bypass),
    .full_feature_out(full_feat), .usb_req_in(usb_req), .usb_event_in(usb_event),
    .usb_rdata_out(usb_rdata), .usb_overrun_out(overrun));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic s, input logic [7:0] v);
    u_cpu.access(1'b1, s, 1'b0, 1'b0, v, rd_b);
  endtask : wr

  task automatic rd(input logic s);
    u_cpu.access(1'b0, s, 1'b0, 1'b0, 8'h00, rd_b);
  endtask : rd

  task automatic poke(input logic [7:0] adr, input logic [7:0] v);
    wr(1'b0, adr);
    wr(1'b1, v);
  endtask : poke

  task automatic usb(input logic w, input logic b, input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk_in);
    usb_req <= '{w, ~w, b, idx, v};
    @(posedge clk_in);
    usb_req <= '0;
    @(negedge clk_in);
  endtask : usb

  // The request pin is a level, so a bounded poll is enough.
  task automatic wait_drq(input logic lvl);
    int k;
    k = 0;
    while (drq_n !== lvl && k < 40) begin
      @(posedge clk_in);
      k++;
    end
    check({7'h00, drq_n}, {7'h00, lvl});
    if (k == 40) begin
      complete_run();
    end
  endtask : wait_drq

  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    complete_run();
  end

  initial begin
    cm_pin = 1'b1;
    periph_mode = 1'b0;
    usb_event = 8'h00;
    usb_req = '0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check({3'h0, drq_n, irq, oe, full_feat, bypass}, 8'h10);
    wr(1'b0, 8'h10);
    for (int i = 0; i < 16; i++) begin
      img[i] = rnd();
      wr(1'b1, img[i]);
    end
    rd(1'b0);
    check(rd_b, 8'h20);
    wr(1'b0, 8'h10);
    for (int i = 0; i < 16; i++) begin
      rd(1'b1);
      check(rd_b, img[i]);
    end
    for (int i = 0; i < 6; i++) begin
      a = rnd() | 8'h80;
      d = rnd();
      if (i[0]) begin
        wr(1'b0, a);
        u_cpu.access(1'b1, 1'b1, 1'b0, 1'b1, d, rd_b);
      end else begin
        poke(a, d);
      end
      wr(1'b0, a);
      rd(1'b1);
      check(rd_b, d);
    end
    poke(ADDR_HOST_IRQ_EN, 8'h05);
    @(posedge clk_in);
    usb_event <= 8'h02;
    @(posedge clk_in);
    usb_event <= 8'h00;
    repeat (3) @(posedge clk_in);
    check({7'h00, irq}, 8'h00);
    usb_event <= 8'h05;
    @(posedge clk_in);
    usb_event <= 8'h00;
    repeat (3) @(posedge clk_in);
    check({7'h00, irq}, 8'h01);
    wr(1'b0, ADDR_HOST_IRQ_STAT);
    rd(1'b1);
    check(rd_b, 8'h07);
    poke(ADDR_HOST_IRQ_STAT, 8'h05);
    check({7'h00, irq}, 8'h00);
    wr(1'b0, ADDR_HOST_IRQ_STAT);
    rd(1'b1);
    check(rd_b, 8'h02);
    poke(ADDR_SET_A_BASE, 8'h30);
    poke(ADDR_SET_A_LEN, 8'h04);
    d = rnd();
    usb(1'b1, 1'b0, 8'h02, d);
    check({7'h00, overrun}, 8'h00);
    usb(1'b0, 1'b0, 8'h02, 8'h00);
    check(usb_rdata, d);
    usb(1'b1, 1'b0, 8'h04, d);
    check({7'h00, overrun}, 8'h01);
    wr(1'b0, 8'h32);
    rd(1'b1);
    check(rd_b, d);
    poke(ADDR_FULL_FEATURE, 8'h00);
    check({7'h00, full_feat}, 8'h01);
    poke(ADDR_SET_B_BASE, 8'hC0);
    poke(ADDR_SET_B_LEN, 8'h02);
    d = rnd();
    usb(1'b1, 1'b1, 8'h01, d);
    check({7'h00, overrun}, 8'h00);
    wr(1'b0, 8'hC1);
    rd(1'b1);
    check(rd_b, d);
    cm_pin <= 1'b0;
    repeat (5) @(posedge clk_in);
    check({7'h00, bypass}, 8'h01);
    poke(ADDR_DMA_COUNT, 8'h03);
    poke(ADDR_DMA_ADDR, 8'h60);
    poke(ADDR_DMA_CTRL, 8'h03);
    repeat (8) @(posedge clk_in);
    check({7'h00, drq_n}, 8'h01);
    periph_mode <= 1'b1;
    for (int dir = 1; dir >= 0; dir--) begin
      poke(ADDR_DMA_COUNT, 8'h03);
      poke(ADDR_DMA_ADDR, 8'h60);
      poke(ADDR_DMA_CTRL, {6'h00, dir[0], 1'b1});
      for (int i = 0; i < 3; i++) begin
        wait_drq(1'b0);
        u_cpu.access(dir[0], 1'b1, 1'b1, 1'b0, img[i], rd_b);
        if (!dir[0]) begin
          check(rd_b, img[i]);
        end
      end
      wait_drq(1'b1);
    end
    wr(1'b0, 8'h60);
    for (int i = 0; i < 3; i++) begin
      rd(1'b1);
      check(rd_b, img[i]);
    end
    complete_run();
  end
endmodule : usb_ctrl_cpu_port_tb
`default_nettype wire
